// ### core/wtw_pkg.sv
// wtw_pkg: register map, field layout, reset values and mode encodings for the wide timer
// assumes a single 100 MHz clock domain and an AHB-Lite register bus
package wtw_pkg;
	localparam logic [7:0] CTRL_A_OFF = 8'h00;
	localparam logic [7:0] CTRL_B_OFF = 8'h04;
	localparam logic [7:0] CNT_OFF = 8'h08;
	localparam logic [7:0] CMP_A_OFF = 8'h0C;
	localparam logic [7:0] CMP_B_OFF = 8'h10;
	localparam logic [7:0] CAP_OFF = 8'h14;
	localparam logic [7:0] DIR_OFF = 8'h18;
	localparam logic [7:0] STAT_OFF = 8'h1C;
	localparam logic [7:0] MASK_OFF = 8'h20;
	localparam logic [7:0] PRESC_OFF = 8'h24;
	localparam int ACT_A_HI = 7;
	localparam int ACT_A_LO = 6;
	localparam int ACT_B_HI = 5;
	localparam int ACT_B_LO = 4;
	localparam int MODE_LO_HI = 1;
	localparam int MODE_HI_HI = 4;
	localparam int MODE_HI_LO = 3;
	localparam logic [7:0] CTRL_A_MASK = 8'hF3;
	localparam logic [7:0] CTRL_B_MASK = 8'h18;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] BOTTOM_VAL = 16'h0000;
	localparam logic [15:0] MAX_VAL = 16'hFFFF;
	localparam logic [15:0] TOP_8BIT = 16'h00FF;
	localparam logic [15:0] TOP_9BIT = 16'h01FF;
	localparam logic [15:0] TOP_10BIT = 16'h03FF;
	localparam logic [15:0] PRESC_RESET = 16'h0000;
	localparam int ST_OVF = 0;
	localparam int ST_MA = 1;
	localparam int ST_MB = 2;
	localparam int ST_W = 3;
	localparam logic [1:0] ACT_OFF = 2'h0;
	localparam logic [1:0] ACT_TOG = 2'h1;
	localparam logic [1:0] ACT_CLR = 2'h2;
	localparam logic [1:0] ACT_SET = 2'h3;
	typedef enum logic [1:0] {
		WTW_SEQ_NORMAL = 2'h0,
		WTW_SEQ_FAST = 2'h1,
		WTW_SEQ_DUAL = 2'h2
	} wtw_seq_type;
	typedef enum logic [2:0] {
		WTW_TOP_MAX = 3'h0,
		WTW_TOP_8 = 3'h1,
		WTW_TOP_9 = 3'h2,
		WTW_TOP_10 = 3'h3,
		WTW_TOP_CMPA = 3'h4,
		WTW_TOP_CAP = 3'h5
	} wtw_top_type;
	typedef enum logic [1:0] {
		WTW_UPD_NOW = 2'h0,
		WTW_UPD_TOP = 2'h1,
		WTW_UPD_BOT = 2'h2
	} wtw_upd_type;
endpackage : wtw_pkg

// ### core/wtw_timer.sv
// wtw_timer: 16-bit timer/counter with waveform mode decode and two compare outputs
// assumes AHB-Lite single word transfers; inputs synchronous to CLK_I
//
// Decided for this implementation: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module wtw_timer (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	input wire logic PORT_A_I,
	input wire logic PORT_B_I,
	output logic PIN_A_O,
	output logic PIN_A_OE_N_O,
	output logic PIN_B_O,
	output logic PIN_B_OE_N_O,
	output logic IRQ_O
);
	import wtw_pkg::*;
	logic [7:0] ctrl_a_r;
	logic [7:0] ctrl_b_r;
	logic [15:0] cnt_r;
	logic [15:0] cmp_buf_a_r;
	logic [15:0] cmp_buf_b_r;
	logic [15:0] cmp_a_r;
	logic [15:0] cmp_b_r;
	logic [15:0] cap_r;
	logic [1:0] dir_r;
	logic [ST_W-1:0] stat_r;
	logic [ST_W-1:0] mask_r;
	logic [15:0] presc_r;
	logic [15:0] presc_cnt_r;
	logic down_r;
	logic wave_out_a;
	logic wave_out_b;
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic tick;
	logic [3:0] wave_mode_sel;
	logic [1:0] chan_a_output_action;
	logic [1:0] chan_b_output_action;
	wtw_seq_type seq;
	wtw_top_type top_src;
	wtw_upd_type upd;
	logic [15:0] top_val;
	logic at_top;
	logic at_bot;
	logic match_a;
	logic match_b;
	logic ovf_ev;
	logic upd_ev;
	logic cnt_wr;
	logic [ST_W-1:0] ev;

	// fields split out of the control registers
	assign chan_a_output_action = ctrl_a_r[ACT_A_HI:ACT_A_LO];
	assign chan_b_output_action = ctrl_a_r[ACT_B_HI:ACT_B_LO];
	assign wave_mode_sel = {ctrl_b_r[MODE_HI_HI:MODE_HI_LO], ctrl_a_r[MODE_LO_HI:0]};

	// mode table: sequence, TOP source and buffer update point
	always_comb
	begin
		seq = WTW_SEQ_NORMAL;
		top_src = WTW_TOP_MAX;
		upd = WTW_UPD_NOW;
		case (wave_mode_sel)
			4'h0: top_src = WTW_TOP_MAX;
			4'h1, 4'h2, 4'h3:
			begin
				seq = WTW_SEQ_DUAL;
				upd = WTW_UPD_TOP;
				top_src = wtw_top_type'({1'b0, wave_mode_sel[1:0]});
			end
			4'h4: top_src = WTW_TOP_CMPA;
			4'h5, 4'h6, 4'h7:
			begin
				seq = WTW_SEQ_FAST;
				upd = WTW_UPD_TOP;
				top_src = wtw_top_type'({1'b0, wave_mode_sel[1:0]});
			end
			4'h8, 4'h9, 4'hA, 4'hB:
			begin
				seq = WTW_SEQ_DUAL;
				upd = wave_mode_sel[1] ? WTW_UPD_TOP : WTW_UPD_BOT;
				top_src = wave_mode_sel[0] ? WTW_TOP_CMPA : WTW_TOP_CAP;
			end
			4'hC: top_src = WTW_TOP_CAP;
			4'hE, 4'hF:
			begin
				seq = WTW_SEQ_FAST;
				upd = WTW_UPD_TOP;
				top_src = wave_mode_sel[0] ? WTW_TOP_CMPA : WTW_TOP_CAP;
			end
			default: top_src = WTW_TOP_MAX; // reserved mode 13 behaves as normal
		endcase
	end

	always_comb
	begin
		case (top_src)
			WTW_TOP_8: top_val = TOP_8BIT;
			WTW_TOP_9: top_val = TOP_9BIT;
			WTW_TOP_10: top_val = TOP_10BIT;
			WTW_TOP_CMPA: top_val = cmp_a_r;
			WTW_TOP_CAP: top_val = cap_r;
			default: top_val = MAX_VAL;
		endcase
	end

	// a register TOP below the counter wraps at MAX, as software was warned
	assign at_top = (cnt_r == top_val);
	assign at_bot = (cnt_r == BOTTOM_VAL);
	assign match_a = tick && !cnt_wr && (cnt_r == cmp_a_r);
	assign match_b = tick && !cnt_wr && (cnt_r == cmp_b_r);
	always_comb
	begin
		case (seq)
			WTW_SEQ_FAST: ovf_ev = tick && at_top;
			WTW_SEQ_DUAL: ovf_ev = tick && at_bot && down_r;
			default: ovf_ev = tick && (cnt_r == MAX_VAL);
		endcase
	end
	always_comb
	begin
		case (upd)
			WTW_UPD_TOP: upd_ev = tick && at_top;
			WTW_UPD_BOT: upd_ev = tick && at_bot;
			default: upd_ev = 1'b1;
		endcase
	end

	// prescaler: count enable every presc_r+1 clocks
	always_ff @(posedge CLK_I)
	begin
		if (RST_I || presc_cnt_r >= presc_r)
			presc_cnt_r <= 16'h0000;
		else
			presc_cnt_r <= presc_cnt_r + 16'h0001;
	end
	assign tick = (presc_cnt_r >= presc_r);

	// bus slave: zero wait states; a write is visible the cycle after its data phase
	logic ahb_go;
	assign ahb_go = HSEL_I && HREADY_I && HTRANS_I[1];
	assign HREADYOUT_O = 1'b1;
	assign HRESP_O = 1'b0;
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
		begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end
		else
		begin
			wr_pend_r <= ahb_go && HWRITE_I;
			wr_addr_r <= HADDR_I[7:0];
		end
	end
	assign cnt_wr = wr_pend_r && (wr_addr_r == CNT_OFF);
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
			HRDATA_O <= 32'h0000_0000;
		else if (ahb_go && !HWRITE_I)
		begin
			case (HADDR_I[7:0])
				CTRL_A_OFF: HRDATA_O <= {24'h000000, ctrl_a_r};
				CTRL_B_OFF: HRDATA_O <= {24'h000000, ctrl_b_r};
				CNT_OFF: HRDATA_O <= {16'h0000, cnt_r};
				CMP_A_OFF: HRDATA_O <= {16'h0000, cmp_buf_a_r};
				CMP_B_OFF: HRDATA_O <= {16'h0000, cmp_buf_b_r};
				CAP_OFF: HRDATA_O <= {16'h0000, cap_r};
				DIR_OFF: HRDATA_O <= {30'h0, dir_r};
				STAT_OFF: HRDATA_O <= {29'h0, stat_r};
				MASK_OFF: HRDATA_O <= {29'h0, mask_r};
				PRESC_OFF: HRDATA_O <= {16'h0000, presc_r};
				default: HRDATA_O <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
		begin
			ctrl_a_r <= CTRL_RESET;
			ctrl_b_r <= CTRL_RESET;
			cmp_buf_a_r <= 16'h0000;
			cmp_buf_b_r <= 16'h0000;
			cap_r <= 16'h0000;
			dir_r <= 2'h0;
			mask_r <= '0;
			presc_r <= PRESC_RESET;
		end
		else if (wr_pend_r)
		begin
			case (wr_addr_r)
				CTRL_A_OFF: ctrl_a_r <= HWDATA_I[7:0] & CTRL_A_MASK;
				CTRL_B_OFF: ctrl_b_r <= HWDATA_I[7:0] & CTRL_B_MASK;
				CMP_A_OFF: cmp_buf_a_r <= HWDATA_I[15:0];
				CMP_B_OFF: cmp_buf_b_r <= HWDATA_I[15:0];
				CAP_OFF: cap_r <= HWDATA_I[15:0];
				DIR_OFF: dir_r <= HWDATA_I[1:0];
				MASK_OFF: mask_r <= HWDATA_I[ST_W-1:0];
				PRESC_OFF: presc_r <= HWDATA_I[15:0];
				default: ;
			endcase
		end
	end

	// active compare values take the buffer at the mode's update point
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
		begin
			cmp_a_r <= 16'h0000;
			cmp_b_r <= 16'h0000;
		end
		else if (upd_ev)
		begin
			cmp_a_r <= cmp_buf_a_r;
			cmp_b_r <= cmp_buf_b_r;
		end
	end

	// counter and direction
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
		begin
			cnt_r <= BOTTOM_VAL;
			down_r <= 1'b0;
		end
		else if (cnt_wr)
			cnt_r <= HWDATA_I[15:0];
		else if (tick)
		begin
			case (seq)
				WTW_SEQ_DUAL:
				begin
					if (at_top)
					begin
						down_r <= 1'b1;
						cnt_r <= cnt_r - 16'h0001;
					end
					else if (at_bot)
					begin
						down_r <= 1'b0;
						cnt_r <= cnt_r + 16'h0001;
					end
					else if (down_r)
						cnt_r <= cnt_r - 16'h0001;
					else
						cnt_r <= cnt_r + 16'h0001;
				end
				default:
				begin
					down_r <= 1'b0;
					if (at_top)
						cnt_r <= BOTTOM_VAL;
					else
						cnt_r <= cnt_r + 16'h0001;
				end
			endcase
		end
	end

	// next output level; dual-slope match at TOP counts as falling, at BOTTOM as rising
	function automatic logic wave_next(input logic cur, input logic [1:0] act,
		input wtw_seq_type sq, input logic mt, input logic dn, input logic is_a);
		logic r;
		r = cur;
		if (sq == WTW_SEQ_NORMAL)
		begin
			case (act)
				ACT_TOG: r = ~cur;
				ACT_CLR: r = 1'b0;
				ACT_SET: r = 1'b1;
				default: r = cur;
			endcase
		end
		else if (act == ACT_TOG)
			r = (mt && is_a) ? ~cur : cur;
		else if (sq == WTW_SEQ_FAST)
			r = (act == ACT_SET) ? 1'b1 : 1'b0;
		else if (act != ACT_OFF)
			r = (act == ACT_CLR) ? dn : ~dn;
		return r;
	endfunction : wave_next

	// waveform registers; fast PWM TOP event wins over a match at TOP
	logic top_tick;
	assign top_tick = tick && at_top && (seq == WTW_SEQ_FAST);
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
			wave_out_a <= 1'b0;
		else if (top_tick && chan_a_output_action[1])
			wave_out_a <= (chan_a_output_action == ACT_CLR);
		else if (match_a)
			wave_out_a <= wave_next(wave_out_a, chan_a_output_action, seq,
				wave_mode_sel[3], (down_r || at_top) && !at_bot, 1'b1);
	end
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
			wave_out_b <= 1'b0;
		else if (top_tick && chan_b_output_action[1])
			wave_out_b <= (chan_b_output_action == ACT_CLR);
		else if (match_b)
			wave_out_b <= wave_next(wave_out_b, chan_b_output_action, seq,
				wave_mode_sel[3], (down_r || at_top) && !at_bot, 1'b0);
	end

	// pin mux: override port function only when action selects waveform
	logic own_a;
	logic own_b;
	assign own_a = (chan_a_output_action != ACT_OFF) &&
		!(seq != WTW_SEQ_NORMAL && chan_a_output_action == ACT_TOG && !wave_mode_sel[3]);
	assign own_b = (chan_b_output_action != ACT_OFF) &&
		!(seq != WTW_SEQ_NORMAL && chan_b_output_action == ACT_TOG);
	assign PIN_A_O = own_a ? wave_out_a : PORT_A_I;
	assign PIN_B_O = own_b ? wave_out_b : PORT_B_I;
	assign PIN_A_OE_N_O = ~dir_r[0];
	assign PIN_B_OE_N_O = ~dir_r[1];

	// sticky events; a set in the same cycle as a write-one clear wins
	assign ev[ST_OVF] = ovf_ev;
	assign ev[ST_MA] = match_a;
	assign ev[ST_MB] = match_b;
	logic [ST_W-1:0] clr;
	assign clr = (wr_pend_r && wr_addr_r == STAT_OFF) ? HWDATA_I[ST_W-1:0] : '0;
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
			stat_r <= '0;
		else
			stat_r <= (stat_r & ~clr) | ev;
	end
	assign IRQ_O = |(stat_r & mask_r);
endmodule : wtw_timer
`default_nettype wire

// ### test/wtw_timer_props.sv
// wtw_timer_props: port-level checks for the wide timer
// assumes it is bound into wtw_timer; one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module wtw_timer_props
	import wtw_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	input wire logic [31:0] HRDATA_O,
	input wire logic HREADYOUT_O,
	input wire logic HRESP_O,
	input wire logic PORT_A_I,
	input wire logic PORT_B_I,
	input wire logic PIN_A_O,
	input wire logic PIN_A_OE_N_O,
	input wire logic PIN_B_O,
	input wire logic PIN_B_OE_N_O,
	input wire logic IRQ_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	sequence s_wr(logic [7:0] a);
		HSEL_I && HREADY_I && HTRANS_I[1] && HWRITE_I && HADDR_I == {24'h0, a};
	endsequence
	sequence s_rd(logic [7:0] a);
		HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I && HADDR_I == {24'h0, a};
	endsequence
	a_zero_wait: assert property (HREADYOUT_O && !HRESP_O)
		else $error("wait state or error response");
	a_reset_idle: assert property ($fell(RST_I) |-> PIN_A_OE_N_O && PIN_B_OE_N_O && !IRQ_O)
		else $error("pins or irq active after reset");
	a_ctrl_a_rsvd: assert property (s_rd(CTRL_A_OFF) |=> (HRDATA_O & ~32'hF3) == 32'h0)
		else $error("control a reserved bits read nonzero");
	a_ctrl_b_rsvd: assert property (s_rd(CTRL_B_OFF) |=> (HRDATA_O & ~32'h18) == 32'h0)
		else $error("control b reserved bits read nonzero");
	a_unmapped_zero: assert property (s_rd(8'h40) |=> HRDATA_O == 32'h0)
		else $error("unmapped read nonzero");
	a_dir_oe: assert property (s_wr(DIR_OFF) ##1 1'b1 |=> PIN_A_OE_N_O == !$past(HWDATA_I[0])
		&& PIN_B_OE_N_O == !$past(HWDATA_I[1]))
		else $error("driver enable not following direction");
	a_pin_a_port: assert property (s_wr(CTRL_A_OFF) ##1 HWDATA_I[7:6] == 2'h0
		|=> (PIN_A_O == PORT_A_I) [*3])
		else $error("pin a not on port data");
	a_pin_b_port: assert property (s_wr(CTRL_A_OFF) ##1 HWDATA_I[5:4] == 2'h0
		|=> (PIN_B_O == PORT_B_I) [*3])
		else $error("pin b not on port data");
endmodule : wtw_timer_props
bind wtw_timer wtw_timer_props u_props (
	.CLK_I(CLK_I), .RST_I(RST_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
	.HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I),
	.HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O),
	.HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .PORT_A_I(PORT_A_I),
	.PORT_B_I(PORT_B_I), .PIN_A_O(PIN_A_O), .PIN_A_OE_N_O(PIN_A_OE_N_O),
	.PIN_B_O(PIN_B_O), .PIN_B_OE_N_O(PIN_B_OE_N_O), .IRQ_O(IRQ_O)
);
`default_nettype wire

// ### test/testbench.sv
// testbench: register-level tests of the wide timer over AHB-Lite
// assumes wtw_timer and its checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
	$display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module testbench;
	import wtw_pkg::*;
	logic CLK_I = 1'b0;
	logic RST_I = 1'b1;
	logic HSEL_I = 1'b0;
	logic [31:0] HADDR_I = 32'h0;
	logic [1:0] HTRANS_I = 2'h0;
	logic HWRITE_I = 1'b0;
	logic [2:0] HSIZE_I = 3'h2;
	logic [31:0] HWDATA_I = 32'h0;
	logic PORT_A_I = 1'b0;
	logic PORT_B_I = 1'b1;
	wire [31:0] HRDATA_O;
	wire HREADYOUT_O, HRESP_O, PIN_A_O, PIN_A_OE_N_O, PIN_B_O, PIN_B_OE_N_O, IRQ_O;
	logic [31:0] q;
	logic [1:0] lv [3] = '{2'h3, 2'h2, 2'h3};
	int k;
	int n_errors = 0;
	int n_tests = 0;
	wtw_timer DUT (
		.CLK_I(CLK_I), .RST_I(RST_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
		.HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I),
		.HWDATA_I(HWDATA_I), .HREADY_I(HREADYOUT_O), .HRDATA_O(HRDATA_O),
		.HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .PORT_A_I(PORT_A_I),
		.PORT_B_I(PORT_B_I), .PIN_A_O(PIN_A_O), .PIN_A_OE_N_O(PIN_A_OE_N_O),
		.PIN_B_O(PIN_B_O), .PIN_B_OE_N_O(PIN_B_OE_N_O), .IRQ_O(IRQ_O)
	);
	initial
		forever #5 CLK_I = ~CLK_I;
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK_I);
		HSEL_I <= 1'b1;
		HTRANS_I <= 2'h2;
		HWRITE_I <= w;
		HADDR_I <= {24'h0, a};
		do @(posedge CLK_I); while (HREADYOUT_O !== 1'b1);
		HSEL_I <= 1'b0;
		HTRANS_I <= 2'h0;
		HWDATA_I <= d;
		do @(posedge CLK_I); while (HREADYOUT_O !== 1'b1);
		q = HRDATA_O;
	endtask : xfer
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
		xfer(1'b0, a, 32'h0);
		`CHK(n, e, q)
	endtask : rd
	// counts pin a changes, or high samples, over n cycles; sampled mid-cycle
	task automatic cnt(input int n, input logic tg);
		logic p;
		k = 0;
		@(negedge CLK_I);
		p = PIN_A_O;
		repeat (n)
		begin
			@(negedge CLK_I);
			k += tg ? int'(PIN_A_O != p) : int'(PIN_A_O);
			p = PIN_A_O;
		end
	endtask : cnt
	task automatic wrap_up;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up
	initial
	begin
		#100000;
		n_errors++;
		wrap_up();
	end
	initial
	begin
		repeat (10) @(posedge CLK_I);
		RST_I <= 1'b0;
		rd(CTRL_A_OFF, 32'h0, "ctrl_a reset");
		rd(CTRL_B_OFF, 32'h0, "ctrl_b reset");
		rd(8'h40, 32'h0, "unmapped");
		xfer(1'b1, CTRL_A_OFF, 32'hFF);
		rd(CTRL_A_OFF, 32'hF3, "ctrl_a fields");
		xfer(1'b1, CTRL_B_OFF, 32'hFF);
		rd(CTRL_B_OFF, 32'h18, "ctrl_b fields");
		xfer(1'b1, CTRL_A_OFF, 32'h0);
		xfer(1'b1, CTRL_B_OFF, 32'h0);
		PORT_A_I <= 1'b1;
		PORT_B_I <= 1'b0;
		@(negedge CLK_I);
		`CHK("port a", 1'b1, PIN_A_O)
		`CHK("port b", 1'b0, PIN_B_O)
		xfer(1'b1, DIR_OFF, 32'h1);
		@(negedge CLK_I);
		`CHK("oe_n", 2'h1, {PIN_A_OE_N_O, PIN_B_OE_N_O})
		xfer(1'b1, CMP_A_OFF, 32'h10);
		xfer(1'b1, CMP_B_OFF, 32'h5);
		xfer(1'b1, CTRL_B_OFF, 32'h08);
		xfer(1'b1, CNT_OFF, 32'h0);
		for (int i = 0; i < 3; i++)
		begin
			xfer(1'b1, CTRL_A_OFF, {24'h0, lv[i], 6'h30});
			repeat (40) @(posedge CLK_I);
			@(negedge CLK_I);
			`CHK("level a", lv[i][0], PIN_A_O)
		end
		`CHK("level b", 1'b1, PIN_B_O)
		xfer(1'b1, CTRL_A_OFF, 32'h40);
		cnt(170, 1'b1);
		`CHK("toggles", 10, k)
		// normal mode wraps only at MAX, so start just below it
		xfer(1'b1, CTRL_B_OFF, 32'h0);
		xfer(1'b1, CNT_OFF, 32'hFFF0);
		xfer(1'b1, STAT_OFF, 32'hF);
		xfer(1'b0, STAT_OFF, 32'h0);
		`CHK("ovf not yet", 1'b0, q[ST_OVF])
		repeat (30) @(posedge CLK_I);
		xfer(1'b0, STAT_OFF, 32'h0);
		@(negedge CLK_I);
		`CHK("ovf max", 1'b1, q[ST_OVF])
		`CHK("irq masked", 1'b0, IRQ_O)
		xfer(1'b1, MASK_OFF, 32'h1);
		@(negedge CLK_I);
		`CHK("irq on", 1'b1, IRQ_O)
		xfer(1'b1, STAT_OFF, 32'h1);
		@(negedge CLK_I);
		`CHK("irq off", 1'b0, IRQ_O)
		xfer(1'b1, CTRL_B_OFF, 32'h08);
		xfer(1'b1, CTRL_A_OFF, 32'h81);
		xfer(1'b1, CNT_OFF, 32'h0);
		for (int i = 0; i < 2; i++)
		begin
			xfer(1'b1, CMP_A_OFF, i ? 32'hFF : 32'h80);
			repeat (600) @(posedge CLK_I);
			cnt(256, 1'b0);
			`CHK("fast high", i ? 256 : 129, k)
		end
		xfer(1'b1, CTRL_B_OFF, 32'h0);
		xfer(1'b1, CMP_A_OFF, 32'h40);
		xfer(1'b1, CNT_OFF, 32'h0);
		repeat (600) @(posedge CLK_I);
		cnt(510, 1'b0);
		`CHK("dual high", 128, k)
		xfer(1'b1, CTRL_A_OFF, 32'hC1);
		repeat (600) @(posedge CLK_I);
		cnt(510, 1'b0);
		`CHK("dual inverted", 382, k)
		xfer(1'b1, CTRL_A_OFF, 32'h41);
		@(negedge CLK_I);
		`CHK("pwm code 01", 1'b1, PIN_A_O)
		@(posedge CLK_I);
		PORT_A_I <= 1'b0;
		@(negedge CLK_I);
		`CHK("pwm code 01 low", 1'b0, PIN_A_O)
		// top mode bit set: code 01 toggles A on match, B stays on its port
		xfer(1'b1, CTRL_B_OFF, 32'h18);
		xfer(1'b1, CTRL_A_OFF, 32'h53);
		xfer(1'b1, CNT_OFF, 32'h0);
		xfer(1'b1, CMP_A_OFF, 32'h10);
		repeat (600) @(posedge CLK_I);
		cnt(170, 1'b1);
		`CHK("top bit toggles", 10, k)
		`CHK("pin b reserved", 1'b0, PIN_B_O)
		@(posedge CLK_I);
		PORT_B_I <= 1'b1;
		@(negedge CLK_I);
		`CHK("pin b reserved high", 1'b1, PIN_B_O)
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
